/* File: design/sdl_defines.svh */
// Constants of the serial input latch link: widths, reset codes, timing counts.
// Assumes both ends run on one 250 MHz system clock and share these values.
`ifndef SDL_DEFINES_SVH
`define SDL_DEFINES_SVH

`define SDL_WORD_W        16
`define SDL_SEG_W         15
`define SDL_LADDER_W      12
`define SDL_MID_SCALE     16'h8000
`define SDL_SEG_RESET     15'h00FF
`define SDL_LADDER_RESET  12'h000
`define SDL_LAST_BIT      4'hF
`define SDL_PIN_CS        0
`define SDL_PIN_SCLK      1
`define SDL_PIN_DATA      2
`define SDL_PIN_STROBE    3
`define SDL_PIN_IDLE      4'h9
`define SDL_SYS_PERIOD_NS 4
`define SDL_SCLK_PERIOD_NS 64
`define SDL_GAP_NS        30
`define SDL_STROBE_NS     30
`define SDL_HALF_CYC ((`SDL_SCLK_PERIOD_NS + 2 * `SDL_SYS_PERIOD_NS - 1) / (2 * `SDL_SYS_PERIOD_NS))
`define SDL_GAP_CYC  ((`SDL_GAP_NS + `SDL_SYS_PERIOD_NS - 1) / `SDL_SYS_PERIOD_NS)
`define SDL_STROBE_CYC ((`SDL_STROBE_NS + `SDL_SYS_PERIOD_NS - 1) / `SDL_SYS_PERIOD_NS)

`endif

/* File: design/sdl_pkg.sv */
// Types shared by both ends of the serial input latch link.
// Assumes sdl_defines.svh is on the include path.
`include "sdl_defines.svh"

package sdl_pkg;
    typedef logic [`SDL_WORD_W-1:0]   sdl_word_t;   // One data word
    typedef logic [`SDL_SEG_W-1:0]    sdl_seg_t;    // Segment switch set
    typedef logic [`SDL_LADDER_W-1:0] sdl_ladder_t; // Ladder switch set
    typedef logic [3:0]               sdl_pins_t;   // Sampled link pins

    // Master sequencer states
    typedef enum logic [2:0] {
        SDL_IDLE,
        SDL_LOW,
        SDL_HIGH,
        SDL_TAIL,
        SDL_GAP,
        SDL_LOAD
    } sdl_host_state_e;
endpackage : sdl_pkg

/* File: design/sdl_link_if.sv */
// Three-wire link plus load strobe between master and converter front end.
// Assumes all wires are one-way; the master drives every one of them.
interface sdl_link_if;
    logic frame_sel_n;         // Frame select, low while a word is sent
    logic sclk;                // Serial clock made by the master
    logic serial_in;           // Serial data, MSB first
    logic latch_load_strobe_n; // Latch load strobe, active low

    modport master (output frame_sel_n, output sclk, output serial_in, output latch_load_strobe_n);
    modport slave  (input frame_sel_n, input sclk, input serial_in, input latch_load_strobe_n);
endinterface : sdl_link_if

/* File: design/sdl_device.sv */
// Converter front end: serial shift register, input register and converter latch.
// Assumes the link pins are asynchronous to sys_clk_i and change no faster
// than a few system cycles; they are filtered before use.
//
// Functional notes
// - Sixteen-bit words and sixteen-bit data registers
// - Reset presets input register, latch to mid-scale
// - Shift register not cleared at reset
// - Extra bits: keep last sixteen; fewer keep old
// - Master shifts sixteen bits for first load
// - Master pads short words with trailing zeros
// - Frame select high: clock and data ignored
// - Data changes on falling, sampled rising, MSB first
// - Frame select rise copies shift to input register
// - Long frame transfers last sixteen sampled bits
// - Master ends frame half a clock period after sixteenth fall
// - Frame select stays low for all sixteen clocks
// - Strobe low after frame updates latch clocklessly
// - Strobe held high while frame select low
// - Strobe tied low: latch follows each load
// - Top nibble to segments, low twelve to ladder
// - Latch code is unsigned binary over 65536
// - Bipolar: offset binary, step reference/32768
// - Master stays at or below fifty megabits
// - Strobe low keeps latch transparent to input
`include "sdl_defines.svh"

module sdl_device
    import sdl_pkg::*;
(
    input  wire logic        sys_clk_i,             // System clock, 250 MHz
    input  wire logic        resetn_i,              // Asynchronous reset, active low
    input  wire logic        ce_i,                  // Clock enable, freezes all state
    sdl_link_if.slave        link,                  // Link from the master
    output logic [15:0]      latch_code_o,          // Converter latch code
    output logic [14:0]      segment_switch_ctrl_o, // Thermometer segment switches
    output logic [11:0]      ladder_switch_ctrl_o,  // Ladder switches
    output logic [15:0]      input_word_o,          // Input register contents
    output logic             word_loaded_o          // Pulse: input register loaded
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Filtered level takes the sampled value only once two stages agree
    function automatic sdl_pins_t filter_pins(input sdl_pins_t s2, input sdl_pins_t s3,
                                              input sdl_pins_t held);
        sdl_pins_t differ;
        differ = s2 ^ s3;
        return (s3 & ~differ) | (held & differ);
    endfunction : filter_pins

    // Top nibble to a 15-bit thermometer: switch i closes when nibble > i
    function automatic sdl_seg_t seg_decode(input logic [3:0] nibble);
        sdl_seg_t seg;
        seg = '0;
        for (int i = 0; i < `SDL_SEG_W; i++)
        begin
            seg[i] = (nibble > 4'(i));
        end
        return seg;
    endfunction : seg_decode

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling

    sdl_pins_t pins_raw;     // Pins as they arrive
    sdl_pins_t sync1;        // First stage, read only by sync2
    sdl_pins_t sync2;        // Second stage
    sdl_pins_t sync3;        // Third stage
    sdl_pins_t filt;         // Filtered pin levels
    sdl_pins_t next_filt;    // Next filtered levels

    assign pins_raw[`SDL_PIN_CS]     = link.frame_sel_n;
    assign pins_raw[`SDL_PIN_SCLK]   = link.sclk;
    assign pins_raw[`SDL_PIN_DATA]   = link.serial_in;
    assign pins_raw[`SDL_PIN_STROBE] = link.latch_load_strobe_n;

    // Filter update; a glitch shorter than one cycle never reaches filt
    always_comb
    begin
        next_filt = filter_pins(sync2, sync3, filt);
    end

    // Three-stage sampler, idle levels at reset
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync1 <= `SDL_PIN_IDLE;
            sync2 <= `SDL_PIN_IDLE;
            sync3 <= `SDL_PIN_IDLE;
            filt  <= `SDL_PIN_IDLE;
        end
        else if (ce_i)
        begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= next_filt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on filtered pins

    logic selected;    // Frame select seen low
    logic sclk_rise;   // Serial clock rising edge
    logic frame_end;   // Frame select rising edge
    logic strobe_low;  // Load strobe seen low

    always_comb
    begin
        selected   = ~filt[`SDL_PIN_CS];
        // Clock edges outside a frame are dropped
        sclk_rise  = selected & ~filt[`SDL_PIN_SCLK] & next_filt[`SDL_PIN_SCLK];
        frame_end  = selected & next_filt[`SDL_PIN_CS];
        strobe_low = ~next_filt[`SDL_PIN_STROBE];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift register, no reset on purpose

    sdl_word_t shift;       // Serial shift register
    sdl_word_t next_shift;  // Next shift contents

    // Data is stable at the rising edge since the master moves it on falling
    always_comb
    begin
        next_shift = shift;
        if (sclk_rise)
        begin
            // MSB first; oldest bit drops off so the last 16 stay
            next_shift = {shift[`SDL_WORD_W-2:0], filt[`SDL_PIN_DATA]};
        end
    end

    // Undefined until bits arrive; saves a reset net on a wide register
    always_ff @(posedge sys_clk_i)
    begin
        if (ce_i)
        begin
            shift <= next_shift;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input register and converter latch

    sdl_word_t   input_reg;        // Input register
    sdl_word_t   next_input_reg;   // Next input register
    sdl_word_t   latch;            // Converter latch
    sdl_word_t   next_latch;       // Next latch
    sdl_seg_t    seg;              // Registered segment controls
    sdl_seg_t    next_seg;         // Next segment controls
    sdl_ladder_t ladder;           // Registered ladder controls
    sdl_ladder_t next_ladder;      // Next ladder controls
    logic        loaded;           // Load pulse register
    logic        next_loaded;      // Next load pulse

    // Load on frame end, latch transparent while the strobe is low
    always_comb
    begin
        next_input_reg = input_reg;
        next_loaded    = 1'b0;
        if (frame_end)
        begin
            // Includes a bit shifted in the same cycle, so none is lost
            next_input_reg = next_shift;
            next_loaded    = 1'b1;
        end
        next_latch = latch;
        if (strobe_low)
        begin
            // Same-cycle follow when strobe tied low
            next_latch = next_input_reg;
        end
        // Code is plain unsigned; bipolar offset is analog only
        next_seg    = seg_decode(next_latch[15:12]);
        next_ladder = next_latch[`SDL_LADDER_W-1:0];
    end

    // Mid-scale preset on reset
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            input_reg <= `SDL_MID_SCALE;
            latch     <= `SDL_MID_SCALE;
            seg       <= `SDL_SEG_RESET;
            ladder    <= `SDL_LADDER_RESET;
            loaded    <= 1'b0;
        end
        else if (ce_i)
        begin
            input_reg <= next_input_reg;
            latch     <= next_latch;
            seg       <= next_seg;
            ladder    <= next_ladder;
            loaded    <= next_loaded;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops

    assign latch_code_o          = latch;
    assign segment_switch_ctrl_o = seg;
    assign ladder_switch_ctrl_o  = ladder;
    assign input_word_o          = input_reg;
    assign word_loaded_o         = loaded;

endmodule : sdl_device

/* File: design/sdl_host.sv */
// Link master: takes words from a two-entry buffer and sends them as frames.
// Assumes the converter end samples the link on its own clock with filtering.
`include "sdl_defines.svh"

module sdl_host
    import sdl_pkg::*;
(
    input  wire logic        sys_clk_i,  // System clock, 250 MHz
    input  wire logic        resetn_i,   // Asynchronous reset, active low
    input  wire logic        ce_i,       // Clock enable, freezes all state
    input  wire logic [15:0] word_i,     // Word to send
    input  wire logic        load_i,     // Pulse strobe after this word
    input  wire logic        valid_i,    // Word offered
    output logic             ready_o,    // Buffer can take a word
    output logic             busy_o,     // Frame or strobe in progress
    sdl_link_if.master       link        // Link to the converter
);

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer; its ready stalls the user when both entries wait

    logic [16:0]     buf_mem [2];      // Word plus load flag
    logic [16:0]     next_buf_mem [2];
    logic            wr_ptr, next_wr_ptr;
    logic            rd_ptr, next_rd_ptr;
    logic [1:0]      count, next_count;
    logic            ready, next_ready;
    logic            push, pop;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state

    sdl_host_state_e state, next_state;   // Frame sequencer
    logic [3:0]      timer, next_timer;   // Phase countdown
    logic [3:0]      bitn,  next_bitn;    // Bit index within frame
    sdl_word_t       frame, next_frame;   // Outgoing shift word
    logic            load,  next_load;    // Strobe wanted after frame
    logic            cs_n,  next_cs_n;
    logic            sclk,  next_sclk;
    logic            dout,  next_dout;
    logic            stb_n, next_stb_n;
    logic            busy,  next_busy;

    // Buffer and sequencer next values
    always_comb
    begin
        push         = valid_i & ready;
        pop          = (state == SDL_IDLE) && (count != 2'h0);
        next_buf_mem = buf_mem;
        next_wr_ptr  = wr_ptr;
        next_rd_ptr  = rd_ptr;
        if (push)
        begin
            next_buf_mem[wr_ptr] = {load_i, word_i};
            next_wr_ptr          = ~wr_ptr;
        end
        if (pop)
        begin
            next_rd_ptr = ~rd_ptr;
        end
        next_count = count + 2'(push) - 2'(pop);
        next_ready = (next_count != 2'h2);

        next_state  = state;
        next_timer  = (timer == 4'h0) ? 4'h0 : timer - 4'h1;
        next_bitn   = bitn;
        next_frame  = frame;
        next_load   = load;
        next_cs_n   = cs_n;
        next_sclk   = sclk;
        next_dout   = dout;
        next_stb_n  = stb_n;
        case (state)
            SDL_IDLE:
            begin
                // Strobe stays high for the whole frame
                if (pop)
                begin
                    next_frame = buf_mem[rd_ptr][15:0];
                    next_load  = buf_mem[rd_ptr][16];
                    next_cs_n  = 1'b0;
                    next_dout  = buf_mem[rd_ptr][15];
                    next_bitn  = 4'h0;
                    next_timer = 4'(`SDL_HALF_CYC - 1);
                    next_state = SDL_LOW;
                end
            end
            SDL_LOW:
            begin
                if (timer == 4'h0)
                begin
                    next_sclk  = 1'b1;
                    next_timer = 4'(`SDL_HALF_CYC - 1);
                    next_state = SDL_HIGH;
                end
            end
            SDL_HIGH:
            begin
                if (timer == 4'h0)
                begin
                    // Data moves on the falling edge
                    next_sclk  = 1'b0;
                    next_timer = 4'(`SDL_HALF_CYC - 1);
                    if (bitn == `SDL_LAST_BIT)
                    begin
                        next_state = SDL_TAIL;
                    end
                    else
                    begin
                        next_bitn  = bitn + 4'h1;
                        next_frame = {frame[14:0], 1'b0};
                        next_dout  = frame[14];
                        next_state = SDL_LOW;
                    end
                end
            end
            SDL_TAIL:
            begin
                if (timer == 4'h0)
                begin
                    next_cs_n  = 1'b1;
                    next_timer = 4'(`SDL_GAP_CYC - 1);
                    next_state = SDL_GAP;
                end
            end
            SDL_GAP:
            begin
                if (timer == 4'h0)
                begin
                    if (load)
                    begin
                        next_stb_n  = 1'b0;
                        next_timer  = 4'(`SDL_STROBE_CYC - 1);
                        next_state  = SDL_LOAD;
                    end
                    else
                    begin
                        next_state = SDL_IDLE;
                    end
                end
            end
            SDL_LOAD:
            begin
                if (timer == 4'h0)
                begin
                    next_stb_n  = 1'b1;
                    next_state  = SDL_IDLE;
                end
            end
            default:
            begin
                next_state = SDL_IDLE;
            end
        endcase
        next_busy = (next_state != SDL_IDLE);
    end

    // Registers only; buffer contents need no reset
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
            ready  <= 1'b1;
            state  <= SDL_IDLE;
            timer  <= 4'h0;
            bitn   <= 4'h0;
            frame  <= 16'h0000;
            load   <= 1'b0;
            cs_n   <= 1'b1;
            sclk   <= 1'b0;
            dout   <= 1'b0;
            stb_n  <= 1'b1;
            busy   <= 1'b0;
        end
        else if (ce_i)
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            ready  <= next_ready;
            state  <= next_state;
            timer  <= next_timer;
            bitn   <= next_bitn;
            frame  <= next_frame;
            load   <= next_load;
            cs_n   <= next_cs_n;
            sclk   <= next_sclk;
            dout   <= next_dout;
            stb_n  <= next_stb_n;
            busy   <= next_busy;
        end
    end

    // Buffer storage
    always_ff @(posedge sys_clk_i)
    begin
        if (ce_i)
        begin
            buf_mem <= next_buf_mem;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign ready_o                  = ready;
    assign busy_o                   = busy;
    assign link.frame_sel_n         = cs_n;
    assign link.sclk                = sclk;
    assign link.serial_in           = dout;
    assign link.latch_load_strobe_n = stb_n;

endmodule : sdl_host

/* File: sim/sdl_props.sv */
// Concurrent checks on the link wires between master and converter front end.
// Assumes instantiation beside the link interface, on the system clock domain.
module sdl_props
(
    input  wire logic sys_clk_i,          // System clock
    input  wire logic resetn_i,           // Asynchronous reset, active low
    input  wire logic frame_sel_n,        // Frame select, low in a frame
    input  wire logic sclk,               // Serial clock from the master
    input  wire logic serial_in,          // Serial data
    input  wire logic latch_load_strobe_n // Latch strobe, active low
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       sclk_q;        // Serial clock one cycle back
    logic [4:0] rise_cnt;      // Serial clock rises in this frame
    logic [4:0] next_rise_cnt; // Next rise count

    ////////////////////////////////////////////////////////////
    // Rise counter: cleared while deselected, no wrap in legal use
    always_comb
    begin
        next_rise_cnt = frame_sel_n ? 5'h00 : rise_cnt + 5'(sclk & ~sclk_q);
    end

    // Registers only
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sclk_q   <= 1'b0;
            rise_cnt <= 5'h00;
        end
        else
        begin
            sclk_q   <= sclk;
            rise_cnt <= next_rise_cnt;
        end
    end

    ////////////////////////////////////////////////////////////
    // One clock domain, so one default clocking and disable
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_clock_idle_low: assert property (frame_sel_n |-> !sclk)
        else $error("serial clock moved while deselected");
    a_data_on_fall: assert property (!frame_sel_n && !$fell(frame_sel_n) && $changed(serial_in) |-> $fell(sclk))
        else $error("serial data changed away from a falling clock");
    a_strobe_quiet_frame: assert property (!frame_sel_n |-> latch_load_strobe_n)
        else $error("latch strobe low inside a frame");
    a_sixteen_clocks: assert property ($rose(frame_sel_n) |-> rise_cnt == 5'h10)
        else $error("frame did not carry sixteen clocks");
    a_end_after_last: assert property ($fell(sclk) && rise_cnt == 5'h10 |-> ##[1:16] $rose(frame_sel_n))
        else $error("frame not closed after the sixteenth clock");
    a_high_phase_min: assert property ($rose(sclk) |-> sclk [*3])
        else $error("serial clock high phase too short");
    a_low_phase_min: assert property ($fell(sclk) |-> (!sclk) [*3])
        else $error("serial clock low phase too short");
    a_strobe_width: assert property ($fell(latch_load_strobe_n) |-> (!latch_load_strobe_n) [*8])
        else $error("latch strobe pulse too short");
    a_strobe_after_gap: assert property ($fell(latch_load_strobe_n) |-> frame_sel_n && $past(frame_sel_n, 7))
        else $error("latch strobe too soon after frame end");
endmodule : sdl_props

/* File: sim/tb_top.sv */
// Bench: host drives one device over link_a; the bench drives a second device on link_b.
// Assumes design files and sdl_props are compiled first, defines on include path.
`include "sdl_defines.svh"

module tb_top
    import sdl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk_i;   // System clock, 4 ns
    logic        resetn_i;    // Reset, active low
    logic        ce = 1'b1;   // Enable to every end
    sdl_word_t   word_i;      // Word offered to host
    logic        load_i;      // Strobe request with word
    logic        valid_i;     // Offer valid
    logic        ready_o;     // Host buffer room
    logic        busy_o;      // Host sequencer busy
    sdl_word_t   latch_a;     // Latch, host-driven device
    sdl_word_t   input_a;     // Input register, same
    sdl_seg_t    seg_a;       // Segments, same
    sdl_ladder_t lad_a;       // Ladder, same
    logic        loaded_a;    // Load pulse, same
    sdl_word_t   latch_b;     // Latch, bench-driven device
    sdl_word_t   input_b;     // Input register, same
    sdl_seg_t    seg_b;       // Segments, same
    sdl_ladder_t lad_b;       // Ladder, same
    sdl_word_t   prev_lat;    // Latch seen one edge back
    logic        saw_full = 1'b0; // Host buffer refused once
    int          n_mismatch = 0;  // Mismatches
    int          checks_done = 0; // Comparisons
    sdl_word_t   exp_in[$];   // Words due at input register
    sdl_word_t   exp_lat[$];  // Words due at latch

    sdl_link_if link_a();
    sdl_link_if link_b();

    sdl_host u_sdl_host (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce), .word_i(word_i), .load_i(load_i),
        .valid_i(valid_i), .ready_o(ready_o), .busy_o(busy_o), .link(link_a.master));
    sdl_device u_sdl_device (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce), .link(link_a.slave),
        .latch_code_o(latch_a), .segment_switch_ctrl_o(seg_a), .ladder_switch_ctrl_o(lad_a),
        .input_word_o(input_a), .word_loaded_o(loaded_a));
    // Second device faces the bench, which can break the master's rules
    sdl_device u_sdl_device_b (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce), .link(link_b.slave),
        .latch_code_o(latch_b), .segment_switch_ctrl_o(seg_b), .ladder_switch_ctrl_o(lad_b),
        .input_word_o(input_b), .word_loaded_o());
    sdl_props u_props (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .frame_sel_n(link_a.frame_sel_n),
        .sclk(link_a.sclk), .serial_in(link_a.serial_in), .latch_load_strobe_n(link_a.latch_load_strobe_n));

    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Latch plus decoded switches; thermometer bit i set when nibble above i
    task automatic check_out(input sdl_word_t exp, input sdl_word_t lat, input sdl_seg_t sg, input sdl_ladder_t ld);
        sdl_seg_t t;
        for (int i = 0; i < 15; i++)
            t[i] = (exp[15:12] > i);
        check("latch_code", exp, lat);
        check("segments", {1'b0, t}, {1'b0, sg});
        check("ladder", {4'h0, exp[11:0]}, {4'h0, ld});
    endtask : check_out

    // Offer one word; valid stays up so back-to-back pushes need no gap
    task automatic push(input sdl_word_t w, input logic ld);
        int i;
        exp_in.push_back(w);
        if (ld)
            exp_lat.push_back(w);
        word_i  <= w;
        load_i  <= ld;
        valid_i <= 1'b1;
        i = 0;
        do
        begin
            @(posedge sys_clk_i);
            i++;
        end
        while (ready_o !== 1'b1 && i < 2000);
    endtask : push

    // Host quiet for twelve edges in a row, bounded
    task automatic wait_idle();
        int quiet;
        quiet = 0;
        for (int i = 0; i < 10000 && quiet < 12; i++)
        begin
            @(posedge sys_clk_i);
            quiet = (busy_o === 1'b0) ? quiet + 1 : 0;
        end
        check("busy_o", 16'h0000, {15'h0, busy_o});
    endtask : wait_idle

    // One frame on link_b, 16 system cycles per bit; data released inverted
    task automatic send_b(input logic [31:0] bits, input int n);
        link_b.frame_sel_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            link_b.serial_in <= bits[i];
            repeat (8) @(posedge sys_clk_i);
            link_b.sclk <= 1'b1;
            repeat (8) @(posedge sys_clk_i);
            link_b.sclk <= 1'b0;
        end
        repeat (8) @(posedge sys_clk_i);
        link_b.frame_sel_n <= 1'b1;
        link_b.serial_in   <= ~link_b.serial_in;
        repeat (12) @(posedge sys_clk_i);
    endtask : send_b

    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // Monitor of the host-driven device: every load and latch change in order
    always @(posedge sys_clk_i)
    begin
        if (resetn_i === 1'b1 && loaded_a === 1'b1)
            check("input_word", exp_in.pop_front(), input_a);
        if (resetn_i === 1'b1 && latch_a !== prev_lat)
            check_out(exp_lat.pop_front(), latch_a, seg_a, lad_a);
        prev_lat = latch_a;
        if (ready_o === 1'b0)
            saw_full = 1'b1;
    end

    // Watchdog at 40000 edges; whole run needs under 10000 edges
    initial
    begin
        repeat (40000) @(posedge sys_clk_i);
        n_mismatch++;
        $display("Error watchdog expected done seen timeout");
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        resetn_i = 1'b0;
        word_i = 16'h0000;
        load_i = 1'b0;
        valid_i = 1'b0;
        link_b.frame_sel_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.serial_in = 1'b0;
        link_b.latch_load_strobe_n = 1'b1;
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        check_out(`SDL_MID_SCALE, latch_a, seg_a, lad_a);
        check("input_reset", `SDL_MID_SCALE, input_b);
        // Zero-padded byte, no strobe: latch must stay
        push(16'h5A00, 1'b0);
        valid_i <= 1'b0;
        wait_idle();
        check("latch_held", `SDL_MID_SCALE, latch_a);
        // Every top nibble, back to back until the buffer refuses
        for (int n = 0; n < 16; n++)
            push({4'(n), 12'(n * 273)}, 1'b1);
        valid_i <= 1'b0;
        wait_idle();
        check("words_left", 16'h0000, 16'(exp_in.size() + exp_lat.size()));
        check("buffer_full", 16'h0001, {15'h0, saw_full});
        // Bench-driven link: exact, long, short and deselected traffic
        send_b(32'h0000_C3A5, 16);
        check("b_input", 16'hC3A5, input_b);
        check("b_latch_held", `SDL_MID_SCALE, latch_b);
        link_b.latch_load_strobe_n <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        link_b.latch_load_strobe_n <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        check_out(16'hC3A5, latch_b, seg_b, lad_b);
        send_b(32'h000A_BCDE, 20);
        check("b_long", 16'hBCDE, input_b);
        send_b(32'h0000_005A, 8);
        check("b_short", 16'hDE5A, input_b);
        repeat (4)
        begin
            link_b.sclk <= 1'b1;
            link_b.serial_in <= ~link_b.serial_in;
            repeat (8) @(posedge sys_clk_i);
            link_b.sclk <= 1'b0;
            repeat (8) @(posedge sys_clk_i);
        end
        send_b(32'h0000_0003, 4);
        check("b_deselected", 16'hE5A3, input_b);
        ce <= 1'b0;
        send_b(32'h0000_1111, 16);
        ce <= 1'b1;
        check("b_frozen", 16'hE5A3, input_b);
        // Strobe held low: latch transparent and follows each load
        link_b.latch_load_strobe_n <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        check("b_transparent", 16'hE5A3, latch_b);
        send_b(32'h0000_0F0F, 16);
        check_out(16'h0F0F, latch_b, seg_b, lad_b);
        link_b.latch_load_strobe_n <= 1'b1;
        report_and_stop();
    end
endmodule : tb_top
